/* logic/bus_qualifier.sv */
// bus cycle qualifier outputs with reset strap handling
//
// Notes on behaviour
// - dma flag high in periods two to four of a dma cycle
// - dma flag floats during bus hold and during reset
// - low strap low, high strap high: pll off, clock divided by two
// - high strap low, low strap high: core clock equals input clock
// - both straps high by default: core clock times four
// - clock straps latched within three cycles after reset release
// - sync ready is active high, sampled on the clock, no synchronizer
// - sync ready low hands wait control to async ready
// - sync ready pin used as general_io_6 forces internal sync ready low
// - upper select low in the upper block, held high in bus hold
// - upper block defaults to 64 Kbyte from F0000h after reset
// - both float requests low at release float all pins until reset
// - pullup on tristate_request_1 enabled only during reset
// - zone flag is AND of inverted address bits 19 to 16
// - zone flag asserted in period one, dropped in period two
// - zone flag and write strobes float in hold and float mode
// - high byte write is OR of high enable and write; pullup in reset
// - low byte write is OR of address bit 0 and write
// - 8-bit write strobe uses the early address timing
// - plain address bus leads the multiplexed address
`timescale 1ns/1ps
module bus_qualifier (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic external_reset_n,
  input wire logic clock_strap_low,
  input wire logic clock_strap_high,
  input wire logic tristate_request_0,
  input wire logic tristate_request_1,
  input wire logic cycle_req,
  input wire logic req_dma,
  input wire logic req_write,
  input wire logic [19:0] req_addr,
  input wire logic high_byte_enable_n,
  input wire logic bus_hold_grant,
  input wire logic narrow_bus,
  input wire logic sync_ready_in,
  input wire logic async_ready_in,
  input wire logic sync_ready_in_as_gpio,
  input wire logic umem_cfg_wr,
  input wire logic [3:0] umem_cfg_base,
  output logic [19:0] addr_bus,
  output logic addr_bus_oe,
  output logic dma_cycle_flag,
  output logic dma_cycle_flag_oe,
  output logic low_vector_zone_flag,
  output logic low_vector_zone_flag_oe,
  output logic upper_mem_select_n,
  output logic upper_mem_select_oe,
  output logic write_high_byte_n,
  output logic write_high_byte_oe,
  output logic write_high_byte_pullup,
  output logic write_low_byte_n,
  output logic write_low_byte_oe,
  output logic write_strobe_8bit_n,
  output logic write_strobe_8bit_oe,
  output logic tristate_request_1_pullup,
  output busq_pkg::clk_mode_e clock_mode,
  output logic pll_enable,
  output logic pin_float_mode,
  output logic bus_ready,
  output logic cycle_done
);

  strap_if st ();

  strap_capture u_strap (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .external_reset_n(external_reset_n),
    .clock_strap_low(clock_strap_low),
    .clock_strap_high(clock_strap_high),
    .tristate_request_0(tristate_request_0),
    .tristate_request_1(tristate_request_1),
    .st(st.cap)
  );

  // strap results leave straight from the capture flops
  assign clock_mode = st.clock_mode;
  assign pll_enable = st.pll_enable;
  assign pin_float_mode = st.pin_float_mode;
  assign tristate_request_1_pullup = st.reset_active;

  busq_pkg::bus_state_e state;
  busq_pkg::bus_state_e next_state;

  logic async_ready_in_meta;
  logic async_ready_in_sync;
  logic sync_ready_in_int;
  logic ready;
  logic cyc_dma;
  logic cyc_write;
  logic cyc_hbe_n;
  logic [19:0] cyc_addr;
  logic [3:0] umem_base;
  logic start;
  logic block;

  // async ready needs two flops; sync ready is used as sampled
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      async_ready_in_meta <= 1'b0;
      async_ready_in_sync <= 1'b0;
    end
    else
    begin
      async_ready_in_meta <= async_ready_in;
      async_ready_in_sync <= async_ready_in_meta;
    end
  end

  // pin used as general_io_6 reads as not ready
  assign sync_ready_in_int = sync_ready_in_as_gpio ? 1'b0 : sync_ready_in;

  // high sync ready is ready unless used as general_io_6, else async ready decides
  assign ready = sync_ready_in_int | async_ready_in_sync;

  // no new cycle in hold, reset or float mode
  assign block = bus_hold_grant | st.reset_active | st.pin_float_mode;
  assign start = cycle_req & ~block;

  // period sequencing, period three stretched by wait states
  always_comb
  begin
    next_state = state;
    case (state)
      busq_pkg::T_IDLE:
        if (start)
          next_state = busq_pkg::T_1;
      busq_pkg::T_1:
        next_state = busq_pkg::T_2;
      busq_pkg::T_2:
        next_state = busq_pkg::T_3;
      busq_pkg::T_3:
        if (ready)
          next_state = busq_pkg::T_4;
      busq_pkg::T_4:
        next_state = busq_pkg::T_IDLE;
      default:
        next_state = busq_pkg::T_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      state <= busq_pkg::T_IDLE;
    else
      state <= next_state;
  end

  // cycle attributes captured at the start of period one
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cyc_dma <= 1'b0;
      cyc_write <= 1'b0;
      cyc_hbe_n <= 1'b1;
      cyc_addr <= busq_pkg::ADDR_RESET;
    end
    else if (state == busq_pkg::T_IDLE && start)
    begin
      cyc_dma <= req_dma;
      cyc_write <= req_write;
      cyc_hbe_n <= high_byte_enable_n;
      cyc_addr <= req_addr;
    end
  end

  // upper block lower bound, top aligned, 64 to 512 Kbyte
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      umem_base <= busq_pkg::UMEM_BASE_RESET;
    else if (umem_cfg_wr)
    begin
      if (umem_cfg_base < busq_pkg::UMEM_BASE_MIN)
        umem_base <= busq_pkg::UMEM_BASE_MIN;
      else
        umem_base <= umem_cfg_base;
    end
  end

  logic nx_t1;
  logic nx_t24;
  logic nx_t23;
  logic nx_t13;
  logic nx_active;
  logic [19:0] nx_addr;
  logic [3:0] nx_zone;
  logic nx_write;

  // next-cycle view so every pin flop lines up with the period
  assign nx_t1 = next_state == busq_pkg::T_1;
  assign nx_t23 = next_state == busq_pkg::T_2
    || next_state == busq_pkg::T_3;
  assign nx_t24 = nx_t23 || next_state == busq_pkg::T_4;
  assign nx_t13 = nx_t1 || nx_t23;
  assign nx_active = nx_t1 || nx_t24;
  assign nx_addr = (state == busq_pkg::T_IDLE) ? req_addr : cyc_addr;
  assign nx_zone = nx_addr[busq_pkg::ZONE_HI:busq_pkg::ZONE_LO];
  assign nx_write = (state == busq_pkg::T_IDLE) ? req_write : cyc_write;

  // plain address bus valid from period one through four
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      addr_bus <= busq_pkg::ADDR_RESET;
      addr_bus_oe <= 1'b0;
    end
    else
    begin
      addr_bus <= nx_addr;
      addr_bus_oe <= ~block;
    end
  end

  // dma cycle flag
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      dma_cycle_flag <= 1'b0;
      dma_cycle_flag_oe <= 1'b0;
    end
    else
    begin
      dma_cycle_flag <= nx_t24 & cyc_dma;
      dma_cycle_flag_oe <= ~block;
    end
  end

  // low vector zone flag, period one only
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      low_vector_zone_flag <= 1'b0;
      low_vector_zone_flag_oe <= 1'b0;
    end
    else
    begin
      low_vector_zone_flag <= nx_t1 & (&(~nx_zone));
      low_vector_zone_flag_oe <= ~block;
    end
  end

  // upper memory select, forced high during hold
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      upper_mem_select_n <= 1'b1;
      upper_mem_select_oe <= 1'b0;
    end
    else
    begin
      upper_mem_select_n <= bus_hold_grant | ~nx_active
        | (nx_zone < umem_base);
      upper_mem_select_oe <= ~st.reset_active & ~st.pin_float_mode;
    end
  end

  // byte write enables, write active in periods two and three, 8-bit strobe in periods one to three
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      write_high_byte_n <= 1'b1;
      write_low_byte_n <= 1'b1;
      write_strobe_8bit_n <= 1'b1;
    end
    else
    begin
      write_high_byte_n <= cyc_hbe_n | ~(nx_t23 & cyc_write);
      write_low_byte_n <= cyc_addr[busq_pkg::BYTE_SEL]
        | ~(nx_t23 & cyc_write);
      write_strobe_8bit_n <= ~(nx_t13 & nx_write);
    end
  end

  // write pin enables follow the bus width variant
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      write_high_byte_oe <= 1'b0;
      write_high_byte_pullup <= 1'b1;
      write_low_byte_oe <= 1'b0;
      write_strobe_8bit_oe <= 1'b0;
    end
    else
    begin
      write_high_byte_oe <= ~block & ~narrow_bus;
      write_high_byte_pullup <= st.reset_active;
      write_low_byte_oe <= ~block & ~narrow_bus;
      write_strobe_8bit_oe <= ~block & narrow_bus;
    end
  end

  // ready seen and end of cycle for the core
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      bus_ready <= 1'b0;
      cycle_done <= 1'b0;
    end
    else
    begin
      bus_ready <= ready;
      cycle_done <= next_state == busq_pkg::T_4;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_dma_mid;
    (state == busq_pkg::T_2 || state == busq_pkg::T_3
      || state == busq_pkg::T_4) && cyc_dma;
  endsequence

  sequence s_write_t2;
    state == busq_pkg::T_2 && cyc_write;
  endsequence

  sequence s_wait;
    state == busq_pkg::T_3 && !sync_ready_in_int && !async_ready_in_sync;
  endsequence

  property p_dma_flag;
    s_dma_mid |-> dma_cycle_flag;
  endproperty
  a_dma_flag: assert property (p_dma_flag)
    else $error("dma flag low inside a dma cycle");

  property p_dma_float;
    $past(bus_hold_grant) || $past(st.reset_active)
      |-> !dma_cycle_flag_oe;
  endproperty
  a_dma_float: assert property (p_dma_float)
    else $error("dma flag driven in hold or reset");

  property p_sync_ready_in_pass;
    state == busq_pkg::T_3 && sync_ready_in && !sync_ready_in_as_gpio
      |=> state == busq_pkg::T_4;
  endproperty
  a_sync_ready_in_pass: assert property (p_sync_ready_in_pass)
    else $error("sync ready did not end the wait");

  property p_async_ready_in_wait;
    state == busq_pkg::T_3 && !sync_ready_in && async_ready_in_sync
      |=> state == busq_pkg::T_4 ##1 state == busq_pkg::T_IDLE;
  endproperty
  a_async_ready_in_wait: assert property (p_async_ready_in_wait)
    else $error("async ready ignored while sync ready low");

  property p_gpio_wait;
    (s_wait and sync_ready_in_as_gpio) |=> state == busq_pkg::T_3;
  endproperty
  a_gpio_wait: assert property (p_gpio_wait)
    else $error("gpio sync ready treated as ready");

  property p_ucs_hold;
    $past(bus_hold_grant) |-> upper_mem_select_n;
  endproperty
  a_ucs_hold: assert property (p_ucs_hold)
    else $error("upper select low during hold");

  property p_zone;
    state == busq_pkg::T_1 && cyc_addr[19:16] == 4'h0
      |-> low_vector_zone_flag ##1 !low_vector_zone_flag;
  endproperty
  a_zone: assert property (p_zone)
    else $error("zone flag not a period one pulse");

  property p_whb;
    (s_write_t2 and !cyc_hbe_n) |-> !write_high_byte_n;
  endproperty
  a_whb: assert property (p_whb)
    else $error("high byte write missing");

  property p_wlb;
    s_write_t2 |-> write_low_byte_n == cyc_addr[0];
  endproperty
  a_wlb: assert property (p_wlb)
    else $error("low byte write wrong");

  property p_wb_early;
    state == busq_pkg::T_1 && cyc_write |-> !write_strobe_8bit_n;
  endproperty
  a_wb_early: assert property (p_wb_early)
    else $error("8-bit write strobe late");

  property p_float;
    pin_float_mode ##1 pin_float_mode |-> !write_low_byte_oe
      && !low_vector_zone_flag_oe && !upper_mem_select_oe;
  endproperty
  a_float: assert property (p_float)
    else $error("pin driven in float mode");

endmodule

/* logic/busq_pkg.sv */
// constants and types for the bus qualifier and strap block
package busq_pkg;

  localparam int ADDR_W = 20;
  localparam int ZONE_W = 4;

  // address field positions
  localparam int ZONE_HI = 19;
  localparam int ZONE_LO = 16;
  localparam int BYTE_SEL = 0;

  // upper memory block: default 64 Kbyte at F0000h, at most 512 Kbyte
  localparam logic [3:0] UMEM_BASE_RESET = 4'hF;
  localparam logic [3:0] UMEM_BASE_MIN = 4'h8;

  // strap timing in crystal clock cycles
  localparam int STRAP_LATCH_CYCLES = 3;
  localparam int STRAP_SETUP_CYCLES = 4;

  localparam logic [19:0] ADDR_RESET = 20'h00000;

  // bus cycle periods
  typedef enum logic [4:0] {
    T_IDLE = 5'h01,
    T_1 = 5'h02,
    T_2 = 5'h04,
    T_3 = 5'h08,
    T_4 = 5'h10
  } bus_state_e;

  // clocking modes picked by the straps
  typedef enum logic [3:0] {
    CLK_X4 = 4'h1,
    CLK_DIV2 = 4'h2,
    CLK_X1 = 4'h4,
    CLK_RSVD = 4'h8
  } clk_mode_e;

endpackage

/* logic/strap_if.sv */
// strap results passed from the capture module to the qualifier
`timescale 1ns/1ps
interface strap_if;
  busq_pkg::clk_mode_e clock_mode;
  logic pll_enable;
  logic pin_float_mode;
  logic reset_active;

  modport cap (
    output clock_mode,
    output pll_enable,
    output pin_float_mode,
    output reset_active
  );

  modport use_side (
    input clock_mode,
    input pll_enable,
    input pin_float_mode,
    input reset_active
  );
endinterface

/* logic/strap_capture.sv */
// reset strap capture: clock mode and pin float request
`timescale 1ns/1ps
module strap_capture (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic external_reset_n,
  input wire logic clock_strap_low,
  input wire logic clock_strap_high,
  input wire logic tristate_request_0,
  input wire logic tristate_request_1,
  strap_if.cap st
);

  logic ext_prev;
  logic low_d;
  logic high_d;
  logic req0_d;
  logic req1_d;
  logic rise;

  assign rise = external_reset_n & ~ext_prev;

  // pin levels as seen during the last reset cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ext_prev <= 1'b0;
      low_d <= 1'b1;
      high_d <= 1'b1;
      req0_d <= 1'b1;
      req1_d <= 1'b1;
    end
    else
    begin
      ext_prev <= external_reset_n;
      low_d <= clock_strap_low;
      high_d <= clock_strap_high;
      req0_d <= tristate_request_0;
      req1_d <= tristate_request_1;
    end
  end

  // reset state, also drives the pullup enables
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st.reset_active <= 1'b1;
    else
      st.reset_active <= ~external_reset_n;
  end

  // clock mode latched one cycle after the release, then held
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st.clock_mode <= busq_pkg::CLK_X4;
      st.pll_enable <= 1'b1;
    end
    else if (rise)
    begin
      case ({high_d, low_d})
        2'b11: st.clock_mode <= busq_pkg::CLK_X4;
        2'b10: st.clock_mode <= busq_pkg::CLK_DIV2;
        2'b01: st.clock_mode <= busq_pkg::CLK_X1;
        default: st.clock_mode <= busq_pkg::CLK_RSVD;
      endcase
      st.pll_enable <= ~(high_d & ~low_d);
    end
  end

  // float request: both low at the release, cleared by the next reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st.pin_float_mode <= 1'b0;
    else if (!external_reset_n)
      st.pin_float_mode <= 1'b0;
    else if (rise)
      st.pin_float_mode <= ~req0_d & ~req1_d;
  end

  property p_strap_hold;
    @(posedge core_clk) disable iff (!rst_n)
    (external_reset_n && !rise) |=> $stable(st.clock_mode);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("clock mode changed outside a reset release");

endmodule

/* tb/far_mem.sv */
// external memory model answering bus cycles after a set access time
`timescale 1ns/1ps
module far_mem (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic select_n,
  input wire logic [3:0] wait_n,
  output logic sync_ready_in
);
  logic [3:0] cnt;

  // cycles elapsed since the chip select went low, saturating
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || select_n)
      cnt <= 4'h0;
    else if (cnt != 4'hF)
      cnt <= cnt + 4'h1;
  end

  // ready is driven high once the access time has run out
  assign sync_ready_in = (cnt >= wait_n);
endmodule

/* tb/bus_qualifier_and_reset_straps_tb.sv */
// self-checking bench for the bus qualifier and reset straps
`timescale 1ns/1ps
module bus_qualifier_and_reset_straps_tb;
  typedef struct packed {
    logic cl;
    logic ch;
    logic t0;
    logic t1;
    busq_pkg::clk_mode_e m;
    logic pll;
    logic fl;
  } row_s;

  logic core_clk, rst_n, external_reset_n, clock_strap_low, clock_strap_high;
  logic tristate_request_0, tristate_request_1, cycle_req, req_dma, req_write;
  logic high_byte_enable_n, bus_hold_grant, narrow_bus, sync_ready_in;
  logic async_ready_in, sync_ready_in_as_gpio, umem_cfg_wr, addr_bus_oe;
  logic dma_cycle_flag, dma_cycle_flag_oe, low_vector_zone_flag;
  logic low_vector_zone_flag_oe, upper_mem_select_n, upper_mem_select_oe;
  logic write_high_byte_n, write_high_byte_oe, write_high_byte_pullup;
  logic write_low_byte_n, write_low_byte_oe, write_strobe_8bit_n;
  logic write_strobe_8bit_oe, tristate_request_1_pullup, pll_enable;
  logic pin_float_mode, bus_ready, cycle_done, any_oe;
  logic [19:0] req_addr, addr_bus;
  logic [3:0] umem_cfg_base, wait_n;
  busq_pkg::clk_mode_e clock_mode;
  row_s rows [5];
  row_s fl_row;
  int fail_count, n_compared, cycles;

  bus_qualifier uut (
    .core_clk(core_clk), .rst_n(rst_n), .external_reset_n(external_reset_n),
    .clock_strap_low(clock_strap_low), .clock_strap_high(clock_strap_high),
    .tristate_request_0(tristate_request_0),
    .tristate_request_1(tristate_request_1), .cycle_req(cycle_req),
    .req_dma(req_dma), .req_write(req_write), .req_addr(req_addr),
    .high_byte_enable_n(high_byte_enable_n),
    .bus_hold_grant(bus_hold_grant), .narrow_bus(narrow_bus),
    .sync_ready_in(sync_ready_in), .async_ready_in(async_ready_in),
    .sync_ready_in_as_gpio(sync_ready_in_as_gpio), .umem_cfg_wr(umem_cfg_wr),
    .umem_cfg_base(umem_cfg_base), .addr_bus(addr_bus),
    .addr_bus_oe(addr_bus_oe), .dma_cycle_flag(dma_cycle_flag),
    .dma_cycle_flag_oe(dma_cycle_flag_oe),
    .low_vector_zone_flag(low_vector_zone_flag),
    .low_vector_zone_flag_oe(low_vector_zone_flag_oe),
    .upper_mem_select_n(upper_mem_select_n),
    .upper_mem_select_oe(upper_mem_select_oe),
    .write_high_byte_n(write_high_byte_n),
    .write_high_byte_oe(write_high_byte_oe),
    .write_high_byte_pullup(write_high_byte_pullup),
    .write_low_byte_n(write_low_byte_n),
    .write_low_byte_oe(write_low_byte_oe),
    .write_strobe_8bit_n(write_strobe_8bit_n),
    .write_strobe_8bit_oe(write_strobe_8bit_oe),
    .tristate_request_1_pullup(tristate_request_1_pullup),
    .clock_mode(clock_mode), .pll_enable(pll_enable),
    .pin_float_mode(pin_float_mode), .bus_ready(bus_ready),
    .cycle_done(cycle_done)
  );

  far_mem mem (
    .core_clk(core_clk), .rst_n(rst_n), .select_n(upper_mem_select_n),
    .wait_n(wait_n), .sync_ready_in(sync_ready_in)
  );

  // any qualifier pin still driven, select and address excluded
  assign any_oe = low_vector_zone_flag_oe | write_high_byte_oe |
    write_low_byte_oe | write_strobe_8bit_oe | dma_cycle_flag_oe;

  // free running bus clock
  initial
  begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s is %b", $time, what, got);
    end
  endtask

  task automatic chka(input logic [19:0] got, input logic [19:0] exp,
    input string what);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s is %h", $time, what, got);
    end
  endtask

  task automatic chkm(input busq_pkg::clk_mode_e got,
    input busq_pkg::clk_mode_e exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s is %h", $time, what, got);
    end
  endtask

  // one external reset with given straps, then straps disturbed
  task automatic strap(input row_s r);
    @(posedge core_clk);
    external_reset_n <= 1'h0;
    clock_strap_low <= r.cl;
    clock_strap_high <= r.ch;
    tristate_request_0 <= r.t0;
    tristate_request_1 <= r.t1;
    repeat (busq_pkg::STRAP_SETUP_CYCLES + 1) @(posedge core_clk);
    #1;
    chk1(tristate_request_1_pullup, 1'h1, "pullup in reset");
    chk1(dma_cycle_flag_oe, 1'h0, "dma drive in reset");
    chk1(write_high_byte_pullup, 1'h1, "high byte pullup");
    @(posedge core_clk);
    external_reset_n <= 1'h1;
    repeat (busq_pkg::STRAP_LATCH_CYCLES) @(posedge core_clk);
    #1;
    chkm(clock_mode, r.m, "clock mode");
    chk1(pll_enable, r.pll, "pll enable");
    chk1(pin_float_mode, r.fl, "float mode");
    chk1(tristate_request_1_pullup, 1'h0, "pullup after reset");
    chk1(write_high_byte_pullup, 1'h0, "byte pullup after");
    @(posedge core_clk);
    {clock_strap_low, clock_strap_high} <= {!r.cl, !r.ch};
    {tristate_request_0, tristate_request_1} <= {!r.t0, !r.t1};
    repeat (3) @(posedge core_clk);
    #1;
    chkm(clock_mode, r.m, "mode held");
    chk1(pin_float_mode, r.fl, "float held");
  endtask

  // one bus cycle, checked period by period
  task automatic cyc(input logic dma, input logic wr, input logic nb,
    input logic [19:0] a, input logic bh, input logic eu, input int lo,
    input int hi);
    int n;
    @(posedge core_clk);
    {req_dma, req_write, narrow_bus} <= {dma, wr, nb};
    req_addr <= a;
    high_byte_enable_n <= bh;
    cycle_req <= 1'h1;
    @(posedge core_clk);
    cycle_req <= 1'h0;
    #1;
    chka(addr_bus, a, "address");
    chk1(upper_mem_select_n, eu, "upper select");
    chk1(low_vector_zone_flag, a[19:16] == 4'h0, "zone t1");
    chk1(write_strobe_8bit_n, !wr, "byte strobe t1");
    @(posedge core_clk);
    #1;
    chk1(low_vector_zone_flag, 1'h0, "zone t2");
    chk1(dma_cycle_flag, dma, "dma flag t2");
    chk1(write_high_byte_n, bh | !wr, "high byte");
    chk1(write_low_byte_n, a[0] | !wr, "low byte");
    n = 1;
    while (cycle_done !== 1'h1 && n < 40)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk1(n >= lo && n <= hi, 1'h1, "cycle length");
    chk1(dma_cycle_flag, dma, "dma flag t4");
    chk1(write_high_byte_n, 1'h1, "high byte t4");
    @(posedge core_clk);
    #1;
    chk1(upper_mem_select_n, 1'h1, "select idle");
  endtask

  task automatic cfg(input logic [3:0] base);
    @(posedge core_clk);
    umem_cfg_base <= base;
    umem_cfg_wr <= 1'h1;
    @(posedge core_clk);
    umem_cfg_wr <= 1'h0;
  endtask

  // hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("unexpected at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  // main sequence
  initial
  begin
    rows[0] = '{1'h1, 1'h1, 1'h1, 1'h1, busq_pkg::CLK_X4, 1'h1, 1'h0};
    rows[1] = '{1'h0, 1'h1, 1'h1, 1'h1, busq_pkg::CLK_DIV2, 1'h0, 1'h0};
    rows[2] = '{1'h1, 1'h0, 1'h1, 1'h1, busq_pkg::CLK_X1, 1'h1, 1'h0};
    rows[3] = '{1'h1, 1'h1, 1'h0, 1'h1, busq_pkg::CLK_X4, 1'h1, 1'h0};
    rows[4] = '{1'h1, 1'h1, 1'h1, 1'h0, busq_pkg::CLK_X4, 1'h1, 1'h0};
    fl_row = '{1'h1, 1'h1, 1'h0, 1'h0, busq_pkg::CLK_X4, 1'h1, 1'h1};
    {rst_n, external_reset_n, cycle_req, req_dma, req_write} = 5'h00;
    {clock_strap_low, clock_strap_high} = 2'h3;
    {tristate_request_0, tristate_request_1, high_byte_enable_n} = 3'h7;
    {bus_hold_grant, narrow_bus, async_ready_in, sync_ready_in_as_gpio} = 4'h0;
    umem_cfg_wr = 1'h0;
    umem_cfg_base = 4'hF;
    req_addr = 20'h00000;
    wait_n = 4'h0;
    repeat (3) @(posedge core_clk);
    #1;
    chk1(write_high_byte_pullup, 1'h1, "high byte pullup");
    chk1(any_oe | upper_mem_select_oe, 1'h0, "drive in reset");
    @(posedge core_clk);
    rst_n <= 1'h1;
    foreach (rows[i])
      strap(rows[i]);
    cyc(1'h0, 1'h1, 1'h0, 20'hFFFF0, 1'h0, 1'h0, 3, 3);
    cyc(1'h1, 1'h0, 1'h0, 20'h0ABC1, 1'h1, 1'h1, 3, 3);
    cyc(1'h0, 1'h1, 1'h0, 20'h10003, 1'h1, 1'h1, 3, 3);
    cyc(1'h0, 1'h1, 1'h1, 20'h20004, 1'h0, 1'h1, 3, 3);
    cyc(1'h0, 1'h0, 1'h0, 20'hEFFFF, 1'h1, 1'h1, 3, 3);
    wait_n <= 4'h6;
    cyc(1'h1, 1'h1, 1'h0, 20'hF0002, 1'h0, 1'h0, 4, 20);
    wait_n <= 4'hF;
    async_ready_in <= 1'h1;
    cyc(1'h0, 1'h0, 1'h0, 20'hF0004, 1'h1, 1'h0, 3, 10);
    async_ready_in <= 1'h0;
    wait_n <= 4'h0;
    sync_ready_in_as_gpio <= 1'h1;
    fork
      cyc(1'h0, 1'h0, 1'h0, 20'hF0000, 1'h1, 1'h0, 8, 30);
      begin
        repeat (8) @(posedge core_clk);
        #1;
        chk1(bus_ready, 1'h0, "ready in gpio wait");
        @(posedge core_clk);
        async_ready_in <= 1'h1;
      end
    join
    chk1(bus_ready, 1'h1, "async ready seen");
    {async_ready_in, sync_ready_in_as_gpio} <= 2'h0;
    cfg(4'h8);
    cyc(1'h0, 1'h0, 1'h0, 20'h80002, 1'h1, 1'h0, 3, 3);
    cfg(4'h2);
    cyc(1'h0, 1'h0, 1'h0, 20'h7FFFE, 1'h1, 1'h1, 3, 3);
    cyc(1'h0, 1'h0, 1'h0, 20'h80000, 1'h1, 1'h0, 3, 3);
    // bus hold: pins released, select high, no cycle taken
    @(posedge core_clk);
    bus_hold_grant <= 1'h1;
    cycle_req <= 1'h1;
    repeat (2) @(posedge core_clk);
    #1;
    chk1(any_oe, 1'h0, "drive in hold");
    chk1(addr_bus_oe, 1'h0, "address drive in hold");
    chk1(upper_mem_select_n, 1'h1, "select in hold");
    repeat (4)
    begin
      @(posedge core_clk);
      #1;
      chk1(cycle_done, 1'h0, "cycle in hold");
    end
    @(posedge core_clk);
    {bus_hold_grant, cycle_req} <= 2'h0;
    // float mode until the next external reset
    strap(fl_row);
    chk1(any_oe | upper_mem_select_oe, 1'h0, "drive in float");
    strap(rows[0]);
    cyc(1'h1, 1'h1, 1'h0, 20'h00002, 1'h0, 1'h1, 3, 3);
    give_verdict();
  end
endmodule
